/* src/adc_serial_result_port.sv */
// Serial and parallel result port of a 16-bit sampling converter.
// Assumes conv_start_in and conv_done_in are one-cycle core-clock pulses.
//
// How it works
// [R1] With serial_parallel_select low, pins 6 to 11 carry result bits 6 to 11.
// [R2] In serial mode clock_invert_select inverts the shift clock, master or slave.
// [R3] With external clock, the chain input reaches the output 16 clocks into a read.
// [R4] Internal clock and read_mode high: the old result shifts during conversion.
// [R5] Internal clock and read_mode low: the result shifts once conversion is done.
// [R6] Results sit in a shift register and leave most significant bit first.
// [R7] output_coding_select high gives plain binary, low inverts the top bit.
// [R8] Internal clock: each output bit is stable over both shift clock edges.
// [R9] External clock, no inversion: output changes on rising edges.
// [R10] External clock, inverted: output changes on falling edges.
// [R11] clock_source_select decides whether the shift clock pin drives or listens.
// [R12] Low selects the internal clock; high makes output follow the host clock.
// [R13] Internal clock, frame_polarity_select low: frame_marker high over valid data.
// [R14] Internal clock, frame_polarity_select high: frame_marker low over valid data.
// [R15] Serial with external clock: pin 11 is the incomplete_read_flag.
// [R16] A slave read unfinished at the next result is dropped and the flag pulses.
// [R17] A chain host gives 16 clocks per chained converter within one read.
`timescale 1ns/1ps
module adc_serial_result_port (
  // Clock and reset
  input wire logic core_clk_in,
  input wire logic rst_in,
  // AHB-Lite slave
  input wire logic hsel_in,
  input wire logic [31:0] haddr_in,
  input wire logic [1:0] htrans_in,
  input wire logic hwrite_in,
  input wire logic [2:0] hsize_in,
  input wire logic [31:0] hwdata_in,
  input wire logic hready_in,
  output logic hreadyout_out,
  output logic hresp_out,
  output logic [31:0] hrdata_out,
  // Interrupt
  output logic irq_out,
  // Converter core
  input wire logic conv_start_in,
  input wire logic conv_done_in,
  input wire logic [15:0] conv_result_in,
  // Mode select pins
  input wire logic serial_parallel_select_in,
  input wire logic clock_source_select_in,
  input wire logic frame_polarity_select_in,
  input wire logic output_coding_select_in,
  // Multiplexed pins
  input wire logic clock_invert_select_in,
  output logic pin6_out,
  output logic pin6_oe_out,
  input wire logic read_mode_or_chain_input_in,
  output logic pin7_out,
  output logic pin7_oe_out,
  output logic serial_result_out,
  input wire logic shift_clock_in,
  output logic shift_clock_out,
  output logic shift_clock_oe_out,
  output logic frame_marker_out,
  output logic incomplete_read_flag_out
);

  typedef struct packed {
    adc_port_pkg::link_state_t state;
    logic [15:0] result;
    logic [15:0] shreg;
    logic [4:0] bit_cnt;
    logic [1:0] phase;
    logic [7:0] div_cnt;
    logic launch_prev;
    logic sclk;
    logic frame;
    logic [4:0] err_cnt;
    logic [7:0] div;
    logic [adc_port_pkg::EV_W-1:0] status;
    logic [adc_port_pkg::EV_W-1:0] mask;
    logic irq;
    logic wr_pend;
    logic [7:0] wr_addr;
    logic [31:0] rdata;
  } port_state_t;

  port_state_t r;
  port_state_t n;

  logic [adc_port_pkg::SYNC_W-1:0] pins_async;
  logic [adc_port_pkg::SYNC_W-1:0] pins_sync;
  logic ser_mode;
  logic ext_clk;
  logic inv_clk;
  logic frame_pol;
  logic bin_code;
  logic rd_chain;
  logic sclk_lvl;

  // ==========================================================
  // Pin synchronisers
  assign pins_async = {shift_clock_in, read_mode_or_chain_input_in, output_coding_select_in,
                       frame_polarity_select_in, clock_invert_select_in,
                       clock_source_select_in, serial_parallel_select_in};

  pin_sync #(
    .WIDTH(adc_port_pkg::SYNC_W)
  ) u_pin_sync (
    .clk_in(core_clk_in),
    .rst_in(rst_in),
    .async_in(pins_async),
    .sync_out(pins_sync)
  );

  assign ser_mode = pins_sync[adc_port_pkg::LN_SER];
  assign ext_clk = pins_sync[adc_port_pkg::LN_EXT];
  assign inv_clk = pins_sync[adc_port_pkg::LN_INV];
  assign frame_pol = pins_sync[adc_port_pkg::LN_FPOL];
  assign bin_code = pins_sync[adc_port_pkg::LN_BIN];
  assign rd_chain = pins_sync[adc_port_pkg::LN_RDC];
  assign sclk_lvl = pins_sync[adc_port_pkg::LN_SCLK];

  // ==========================================================
  // Helpers
  function automatic logic [15:0] code_result(input logic [15:0] raw, input logic bin);
    code_result = {raw[15] ^ ~bin, raw[14:0]}; // [R7]
  endfunction : code_result

  function automatic logic [31:0] read_word(input logic [7:0] addr, input port_state_t s);
    read_word = 32'h0000_0000;
    unique case (addr)
      adc_port_pkg::OFS_CTRL: read_word = {24'h00_0000, s.div};
      adc_port_pkg::OFS_STATUS: read_word = {29'h0000_0000, s.status};
      adc_port_pkg::OFS_MASK: read_word = {29'h0000_0000, s.mask};
      adc_port_pkg::OFS_STATE: read_word = {16'h0000, 4'h0, s.err_cnt != 5'h00,
                                            s.bit_cnt, s.phase, s.frame, s.sclk, s.state};
      adc_port_pkg::OFS_RESULT: read_word = {16'h0000, s.result};
      default: read_word = 32'h0000_0000;
    endcase
  endfunction : read_word

  // ==========================================================
  // Next state
  always_comb begin
    logic tick;
    logic launch_lvl;
    logic launch_edge;
    logic start;
    logic [adc_port_pkg::EV_W-1:0] ev;
    logic [adc_port_pkg::EV_W-1:0] clr;
    tick = 1'b0;
    launch_lvl = 1'b0;
    launch_edge = 1'b0;
    start = 1'b0;
    ev = '0;
    clr = '0;
    n = r;

    // Result capture, always in stored coding
    if (conv_done_in) begin
      n.result = code_result(conv_result_in, bin_code); // [R6]
      ev[adc_port_pkg::EV_LOADED] = 1'b1;
    end

    // Host clock edges, inversion picks the launch edge
    launch_lvl = sclk_lvl ^ inv_clk; // [R2] [R10]
    launch_edge = launch_lvl & ~r.launch_prev; // [R9] [R10]
    n.launch_prev = launch_lvl;

    // Internal clock divider
    // Compare with >= so a lowered divisor never waits out a full wrap
    if (r.div_cnt >= r.div) begin
      tick = 1'b1;
      n.div_cnt = 8'h00;
    end else begin
      n.div_cnt = r.div_cnt + 8'h01;
    end

    if (r.err_cnt != 5'h00) begin
      n.err_cnt = r.err_cnt - 5'h01;
    end

    if (!ser_mode) begin
      n.state = adc_port_pkg::ST_IDLE;
      n.frame = 1'b0;
      n.phase = 2'h0;
      n.bit_cnt = 5'h00;
    end else if (ext_clk) begin
      // Slave: output follows the host clock
      if (launch_edge) begin
        n.shreg = {r.shreg[14:0], rd_chain}; // [R3] [R6] [R12]
        if (r.bit_cnt != adc_port_pkg::FRAME_BITS) begin
          n.bit_cnt = r.bit_cnt + 5'h01;
        end
        if (r.bit_cnt == adc_port_pkg::LAST_BIT) begin
          n.state = adc_port_pkg::ST_IDLE;
          ev[adc_port_pkg::EV_FRAME_DONE] = 1'b1;
        end else if (r.state == adc_port_pkg::ST_LOADED) begin
          n.state = adc_port_pkg::ST_SHIFT;
        end
      end
      if (conv_done_in) begin
        if (r.state == adc_port_pkg::ST_SHIFT) begin
          n.err_cnt = adc_port_pkg::ERR_PULSE_CYCLES; // [R16]
          ev[adc_port_pkg::EV_RD_ERROR] = 1'b1; // [R16]
        end
        n.shreg = code_result(conv_result_in, bin_code); // [R16]
        n.bit_cnt = 5'h00;
        n.state = adc_port_pkg::ST_LOADED;
      end
      n.frame = 1'b0;
      n.phase = 2'h0;
    end else begin
      // Master: four phases per bit, data moves only while the clock rests at its idle level (low, high when inverted)
      unique case (r.state)
        adc_port_pkg::ST_IDLE, adc_port_pkg::ST_LOADED: begin
          start = rd_chain ? conv_start_in : conv_done_in; // [R4] [R5]
          if (start) begin
            n.shreg = rd_chain ? r.result : code_result(conv_result_in, bin_code); // [R4] [R5]
            n.state = adc_port_pkg::ST_SHIFT;
            n.frame = 1'b1; // [R13] [R14]
            n.phase = 2'h0;
            n.bit_cnt = 5'h00;
          end else begin
            n.state = adc_port_pkg::ST_IDLE;
          end
        end
        adc_port_pkg::ST_SHIFT: begin
          if (tick) begin
            n.phase = r.phase + 2'h1;
            if (r.phase == adc_port_pkg::PH_LAST) begin
              n.bit_cnt = r.bit_cnt + 5'h01;
              if (r.bit_cnt == adc_port_pkg::LAST_BIT) begin
                n.state = adc_port_pkg::ST_IDLE;
                n.frame = 1'b0; // [R13] [R14]
                ev[adc_port_pkg::EV_FRAME_DONE] = 1'b1;
              end else begin
                n.shreg = {r.shreg[14:0], 1'b0}; // [R6] [R8]
              end
            end
          end
        end
      endcase
    end

    // Clock pin level: high only in the rise phase, then inverted on request
    n.sclk = ((r.state == adc_port_pkg::ST_SHIFT) && !ext_clk && ser_mode &&
              (n.phase == adc_port_pkg::PH_RISE)) ^ inv_clk; // [R2] [R8] [R12]

    // Bus data phase write; a read just after a write sees the old value
    if (r.wr_pend) begin
      unique case (r.wr_addr)
        adc_port_pkg::OFS_CTRL: n.div = hwdata_in[7:0];
        adc_port_pkg::OFS_STATUS: clr = hwdata_in[adc_port_pkg::EV_W-1:0];
        adc_port_pkg::OFS_MASK: n.mask = hwdata_in[adc_port_pkg::EV_W-1:0];
        default: n.div = r.div;
      endcase
    end

    // New events win over a clear in the same cycle
    n.status = (r.status & ~clr) | ev;
    n.irq = |(n.status & n.mask);

    // Bus address phase, zero wait states
    n.wr_pend = 1'b0;
    if (hsel_in && htrans_in[1] && hready_in) begin
      n.wr_pend = hwrite_in;
      n.wr_addr = haddr_in[adc_port_pkg::ADDR_W-1:0];
      n.rdata = hwrite_in ? 32'h0000_0000 : read_word(haddr_in[adc_port_pkg::ADDR_W-1:0], r);
    end
  end

  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      r <= '0;
      r.div <= adc_port_pkg::DIV_RST;
      r.mask <= adc_port_pkg::MASK_RST;
      r.state <= adc_port_pkg::ST_IDLE;
    end else begin
      r <= n;
    end
  end

  // ==========================================================
  // Outputs
  assign hreadyout_out = 1'b1;
  assign hresp_out = 1'b0;
  assign hrdata_out = r.rdata;
  assign irq_out = r.irq;

  // Parallel bits when not serial
  assign pin6_out = r.result[6]; // [R1]
  assign pin6_oe_out = ~ser_mode; // [R1]
  assign pin7_out = r.result[7]; // [R1]
  assign pin7_oe_out = ~ser_mode; // [R1]
  assign serial_result_out = ser_mode ? r.shreg[15] : r.result[8]; // [R1] [R6]
  assign shift_clock_out = ser_mode ? r.sclk : r.result[9]; // [R1] [R11]
  assign shift_clock_oe_out = ~ser_mode | ~ext_clk; // [R11]
  assign frame_marker_out = ser_mode ? (r.frame ^ frame_pol) : r.result[10]; // [R13] [R14]
  assign incomplete_read_flag_out = ser_mode ? (ext_clk & (r.err_cnt != 5'h00))
                                             : r.result[11]; // [R15]

endmodule : adc_serial_result_port

/* src/adc_port_pkg.sv */
// Constants, offsets and types shared by the serial result port.
// Assumes a 125 MHz core clock and a 32-bit AHB-Lite register bus.
package adc_port_pkg;

  // ==========================================================
  // Data path
  localparam int RESULT_W = 16;
  localparam logic [4:0] FRAME_BITS = 5'h10;
  localparam logic [4:0] LAST_BIT = 5'h0f;
  localparam logic [1:0] PH_RISE = 2'h1;
  localparam logic [1:0] PH_LAST = 2'h3;
  localparam logic [4:0] ERR_PULSE_CYCLES = 5'h10;

  // ==========================================================
  // Pin synchroniser lanes
  localparam int SYNC_W = 7;
  localparam int LN_SER = 0;
  localparam int LN_EXT = 1;
  localparam int LN_INV = 2;
  localparam int LN_FPOL = 3;
  localparam int LN_BIN = 4;
  localparam int LN_RDC = 5;
  localparam int LN_SCLK = 6;

  // ==========================================================
  // Register map, byte addresses
  localparam int ADDR_W = 8;
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h04;
  localparam logic [7:0] OFS_MASK = 8'h08;
  localparam logic [7:0] OFS_STATE = 8'h0c;
  localparam logic [7:0] OFS_RESULT = 8'h10;

  // Status and mask layout
  localparam int EV_W = 3;
  localparam int EV_LOADED = 0;
  localparam int EV_FRAME_DONE = 1;
  localparam int EV_RD_ERROR = 2;

  // Reset values
  localparam logic [7:0] DIV_RST = 8'h03;
  localparam logic [EV_W-1:0] MASK_RST = 3'h0;

  // ==========================================================
  // Link states
  typedef enum logic [1:0] {
    ST_IDLE,
    ST_LOADED,
    ST_SHIFT
  } link_state_t;

endpackage : adc_port_pkg

/* src/pin_sync.sv */
// Two-flop synchroniser bank for pins from outside the core clock.
// Assumes each lane is an independent level; no bus coherency.
`timescale 1ns/1ps
module pin_sync #(
  parameter int WIDTH = 1
) (
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_in,
  // Lanes
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);

  typedef struct packed {
    logic [WIDTH-1:0] stage1;
    logic [WIDTH-1:0] stage2;
  } sync_state_t;

  sync_state_t r;
  sync_state_t n;

  // ==========================================================
  // First stage feeds only the second
  always_comb begin
    n = r;
    n.stage1 = async_in;
    n.stage2 = r.stage1;
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end

  assign sync_out = r.stage2;

endmodule : pin_sync

/* dv/adc_port_properties.sv */
// Pin-level checks for the serial result port.
// Assumes binding to adc_serial_result_port; selects held 4 cycles cover their sync.
`timescale 1ns/1ps
module adc_port_properties (
  // Clock and reset
  input wire logic core_clk_in,
  input wire logic rst_in,
  // Watched pins
  input wire logic serial_parallel_select_in,
  input wire logic clock_source_select_in,
  input wire logic clock_invert_select_in,
  input wire logic frame_polarity_select_in,
  input wire logic conv_done_in,
  input wire logic shift_clock_in,
  input wire logic pin6_oe_out,
  input wire logic pin7_oe_out,
  input wire logic shift_clock_oe_out,
  input wire logic serial_result_out,
  input wire logic shift_clock_out,
  input wire logic frame_marker_out,
  input wire logic incomplete_read_flag_out
);
  // ==========
  // Mode shorthands
  wire par = !serial_parallel_select_in;
  wire mst = serial_parallel_select_in && !clock_source_select_in;
  wire slv = serial_parallel_select_in && clock_source_select_in;
  wire inv = clock_invert_select_in;
  wire fpl = frame_polarity_select_in;
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (rst_in);
  // ==========
  // Assertions
  a_par_pins_drive: assert property (
    par [*4] |-> pin6_oe_out && pin7_oe_out && shift_clock_oe_out) else $error("par oe");
  a_ser_pins_listen: assert property (
    !par [*4] |-> !pin6_oe_out && !pin7_oe_out) else $error("ser oe");
  a_clk_dir_sel: assert property (
    !par [*4] |-> shift_clock_oe_out == mst) else $error("clk dir");
  a_mst_clk_idle: assert property (
    (mst && inv && !fpl) [*4] ##0 !frame_marker_out [*2] |-> shift_clock_out)
    else $error("idle clk");
  a_mst_frame_high: assert property (
    (mst && !inv && !fpl) [*4] ##0 $rose(shift_clock_out) |-> frame_marker_out)
    else $error("frame high");
  a_mst_frame_low: assert property (
    (mst && !inv && fpl) [*4] ##0 $rose(shift_clock_out) |-> !frame_marker_out)
    else $error("frame low");
  a_mst_data_hold: assert property (
    (mst && !inv) [*4] ##0 $changed(serial_result_out) |-> !shift_clock_out
    && !$past(shift_clock_out)) else $error("data hold");
  a_slv_rise_launch: assert property (
    (slv && !inv) [*4] ##0 $changed(serial_result_out) && !$past(conv_done_in)
    |-> shift_clock_in && $past(shift_clock_in, 2)) else $error("rise launch");
  a_slv_fall_launch: assert property (
    (slv && inv) [*4] ##0 $changed(serial_result_out) && !$past(conv_done_in)
    |-> !shift_clock_in && !$past(shift_clock_in, 2)) else $error("fall launch");
  a_err_pulse_len: assert property (
    slv [*4] ##0 $rose(incomplete_read_flag_out) |-> incomplete_read_flag_out [*8])
    else $error("flag pulse");
  a_int_no_flag: assert property (
    mst [*4] |-> !incomplete_read_flag_out) else $error("flag in master");
endmodule : adc_port_properties

/* dv/host_link_model.sv */
// Host on the far side of the link: clocks slave reads, captures master frames.
// Assumes go_in rises once per read with edge count and chain bits held.
`timescale 1ns/1ps
module host_link_model (
  // Control
  input wire logic go_in,
  input wire logic [5:0] edges_in,
  input wire logic inv_in,
  input wire logic [15:0] chain_in,
  // Link
  input wire logic serial_result_out_in,
  input wire logic mclk_in,
  output logic sclk_out,
  output logic sdin_out,
  // Results
  output logic [31:0] got_out,
  output logic [15:0] mgot_out,
  output logic busy_out
);
  logic ph = 1'b0;
  // Idle level tracks inversion so no stray launch edge appears
  assign sclk_out = ph ^ inv_in;
  initial begin
    sdin_out = 1'b0;
    got_out = 32'h0;
    mgot_out = 16'h0;
    busy_out = 1'b0;
  end
  // ==========
  // Slave read, clock still between reads
  always @(posedge go_in) begin : rd_frame
    int i;
    busy_out = 1'b1;
    #3;
    for (i = 0; i < edges_in; i++) begin
      got_out = {got_out[30:0], serial_result_out_in};
      sdin_out = (i < 16) ? chain_in[15-i] : ~sdin_out;
      #80 ph = 1'b1;
      #80 ph = 1'b0;
    end
    sdin_out = ~sdin_out;
    busy_out = 1'b0;
  end
  // ==========
  // Master frame capture
  always @(posedge mclk_in) mgot_out <= {mgot_out[14:0], serial_result_out_in};
endmodule : host_link_model

/* dv/tb_adc_serial_result_port.sv */
// Self-checking bench for the serial result port.
// Assumes host_link_model on the link and the bound pin checker.
`timescale 1ns/1ps
module tb_adc_serial_result_port;
  // ==========
  // Signals
  logic core_clk_in, rst_in, hsel, hwrite, cst, cdn, ser, ext, fpol, bin, inv, rdm, go;
  logic hrdy, hresp, irq, p6, p6oe, p7, p7oe, sdo, sclk_i, sclk_o, sclk_oe, frm, flag;
  logic sdin, busy;
  logic [1:0] htrans;
  logic [31:0] haddr, hwdata, hrdata, rd, seed, got;
  logic [15:0] res, chain, mgot, cres;
  logic [5:0] edges;
  int err_total = 0;
  int num_checks = 0;
  int cyc = 0;
  int k;
  adc_serial_result_port uut (.core_clk_in(core_clk_in), .rst_in(rst_in), .hsel_in(hsel),
    .haddr_in(haddr), .htrans_in(htrans), .hwrite_in(hwrite), .hsize_in(3'h2),
    .hwdata_in(hwdata), .hready_in(hrdy), .hreadyout_out(hrdy), .hresp_out(hresp),
    .hrdata_out(hrdata), .irq_out(irq), .conv_start_in(cst), .conv_done_in(cdn),
    .conv_result_in(cres), .serial_parallel_select_in(ser), .clock_source_select_in(ext),
    .frame_polarity_select_in(fpol), .output_coding_select_in(bin),
    .clock_invert_select_in(inv), .pin6_out(p6), .pin6_oe_out(p6oe),
    .read_mode_or_chain_input_in(ext ? sdin : rdm), .pin7_out(p7), .pin7_oe_out(p7oe),
    .serial_result_out(sdo), .shift_clock_in(sclk_i), .shift_clock_out(sclk_o),
    .shift_clock_oe_out(sclk_oe), .frame_marker_out(frm), .incomplete_read_flag_out(flag));
  host_link_model host (.go_in(go), .edges_in(edges), .inv_in(inv), .chain_in(chain),
    .serial_result_out_in(sdo), .mclk_in(sclk_o ^ inv), .sclk_out(sclk_i), .sdin_out(sdin),
    .got_out(got), .mgot_out(mgot), .busy_out(busy));
  initial begin
    core_clk_in = 1'b0;
    forever #4 core_clk_in = ~core_clk_in;
  end
  // ==========
  // Helpers
  function automatic logic [15:0] coded(input logic [15:0] r, input logic b);
    return b ? r : {~r[15], r[14:0]};
  endfunction : coded
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic finish_test();
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : finish_test
  task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    @(posedge core_clk_in);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h0, a};
    hwrite <= wr;
    do @(posedge core_clk_in); while (hrdy !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge core_clk_in); while (hrdy !== 1'b1);
    rd = hrdata;
  endtask : ahb
  task automatic pulse(input logic start, input logic [15:0] r);
    @(posedge core_clk_in);
    cres <= r;
    cdn <= !start;
    cst <= start;
    @(posedge core_clk_in);
    cdn <= 1'b0;
    cst <= 1'b0;
  endtask : pulse
  // Selects change only via parallel mode so no checker sees a half-synced switch
  task automatic mode(input logic s, input logic e, input logic i, input logic f);
    @(posedge core_clk_in);
    ser <= 1'b0;
    repeat (4) @(posedge core_clk_in);
    bin <= 1'($random(seed));
    ser <= s;
    ext <= e;
    inv <= i;
    fpol <= f;
    rdm <= i ^ f;
    repeat (6) @(posedge core_clk_in);
  endtask : mode
  task automatic run_host(input logic [5:0] n);
    edges <= n;
    go <= 1'b1;
    @(posedge core_clk_in);
    go <= 1'b0;
    @(posedge core_clk_in);
    while (busy !== 1'b0) @(posedge core_clk_in);
  endtask : run_host
  always @(posedge core_clk_in) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      err_total++;
      finish_test();
    end
  end
  // ==========
  // Sequence
  initial begin
    seed = 32'hf1774c9d;
    {hsel, hwrite, cst, cdn, ser, ext, fpol, bin, inv, rdm, go} = 11'h0;
    {htrans, haddr, hwdata, cres, chain, edges} = '0;
    rst_in = 1'b1;
    repeat (5) @(posedge core_clk_in);
    rst_in <= 1'b0;
    ahb(1'b0, adc_port_pkg::OFS_CTRL, 32'h0);
    check("ctrl", rd, {24'h00_0000, adc_port_pkg::DIV_RST});
    check("hresp", hresp, 1'b0);
    ahb(1'b0, adc_port_pkg::OFS_MASK, 32'h0);
    check("mask", rd, 32'h0);
    ahb(1'b0, 8'h20, 32'h0);
    check("unmapped", rd, 32'h0);
    for (k = 0; k < 4; k++) begin
      mode(1'b0, 1'b0, 1'b0, 1'b0);
      res = (k == 0) ? 16'h0fc0 : 16'($random(seed));
      pulse(1'b0, res);
      repeat (2) @(posedge core_clk_in);
      check("par", {flag, frm, sclk_o, sdo, p7, p6}, res[11:6]);
      check("par_oe", {p6oe, p7oe, sclk_oe}, 3'h7);
      ahb(1'b0, adc_port_pkg::OFS_RESULT, 32'h0);
      check("result", rd, coded(res, bin));
    end
    for (k = 0; k < 4; k++) begin
      mode(1'b1, 1'b0, k[0], k[1]);
      ahb(1'b1, adc_port_pkg::OFS_CTRL, $random(seed) & 32'h7);
      res = 16'($random(seed));
      pulse(1'b0, res);
      if (k[0] ^ k[1]) pulse(1'b1, 16'h0);
      rd = 32'h0;
      while (rd[1] !== 1'b1) ahb(1'b0, adc_port_pkg::OFS_STATUS, 32'h0);
      ahb(1'b1, adc_port_pkg::OFS_STATUS, 32'h7);
      check("master", mgot, coded(res, bin));
    end
    for (k = 0; k < 2; k++) begin
      mode(1'b1, 1'b1, k[0], 1'b0);
      res = 16'($random(seed));
      chain = 16'($random(seed));
      pulse(1'b0, res);
      run_host(6'h20);
      check("slave", got[31:16], coded(res, bin));
      check("chain", got[15:0], chain);
    end
    check("irq_masked", irq, 1'b0);
    ahb(1'b1, adc_port_pkg::OFS_MASK, 32'h4);
    ahb(1'b1, adc_port_pkg::OFS_STATUS, 32'h7);
    pulse(1'b0, res);
    run_host(6'h5);
    pulse(1'b0, ~res);
    repeat (3) @(posedge core_clk_in);
    check("flag", flag, 1'b1);
    check("irq", irq, 1'b1);
    ahb(1'b0, adc_port_pkg::OFS_STATUS, 32'h0);
    check("err_stat", rd[2], 1'b1);
    ahb(1'b1, adc_port_pkg::OFS_STATUS, 32'h4);
    repeat (2) @(posedge core_clk_in);
    check("irq_clr", irq, 1'b0);
    finish_test();
  end
endmodule : tb_adc_serial_result_port

bind adc_serial_result_port adc_port_properties u_props (.core_clk_in, .rst_in,
  .serial_parallel_select_in, .clock_source_select_in, .clock_invert_select_in,
  .frame_polarity_select_in, .conv_done_in, .shift_clock_in, .pin6_oe_out, .pin7_oe_out,
  .shift_clock_oe_out, .serial_result_out, .shift_clock_out, .frame_marker_out,
  .incomplete_read_flag_out);
